// ---- rtl/vectored_interrupt_acknowledge.sv ----
// interrupt acknowledge, nesting and vector sequencing for the cpu core
//
// Implementation choices: the strobed register port and the register addresses.
module vectored_interrupt_acknowledge #(
   parameter int N_SRC = 12,
   parameter logic [15:0] NMI_VECTOR = 16'h0004
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // interrupt sources, same clock
   input wire logic [N_SRC-1:0] src_event_in,
   input wire logic nmi_event_in,
   // core side
   input wire logic boundary_in,
   input wire logic reserve_in,
   input wire logic brk_in,
   input wire logic ret_vec_in,
   input wire logic ei_in,
   input wire logic di_in,
   input wire logic psw_load_in,
   input wire logic [7:0] psw_load_data_in,
   output logic [7:0] psw_out,
   output logic busy_out,
   output logic push_state_out,
   output logic [7:0] state_word_out,
   output logic push_ptr_out,
   output logic vector_load_out,
   output logic [15:0] vector_out
);
   localparam int IDX_W = 4;

   // whole block state in one word
   typedef struct packed {
      via_pkg::via_seq_e seq;
      logic [7:0] processor_state_word;
      logic [N_SRC-1:0] req;
      logic [N_SRC-1:0] mask;
      logic [N_SRC-1:0] prio;
      logic nmi_pend;
      logic nmi_act;
      logic defer;
      logic low;
      logic [1:0] wait_cnt;
      logic [7:0] saved;
      logic [15:0] vec;
      logic [31:0] rdata;
   } via_state_s;

   via_state_s s_reg;
   via_state_s s_next;

   via_sel_if #(.N_SRC(N_SRC), .IDX_W(IDX_W)) sel ();

   // the picker sees live flags so a boundary decision uses this cycle's state
   assign sel.req = s_reg.req;
   assign sel.mask = s_reg.mask;
   assign sel.prio = s_reg.prio;
   assign sel.ie = s_reg.processor_state_word[via_pkg::IE_BIT];
   assign sel.in_service_priority_flag = s_reg.processor_state_word[via_pkg::ISP_BIT];

   via_picker #(.N_SRC(N_SRC), .IDX_W(IDX_W)) u_picker (
      .sel(sel)
   );

   logic wr_req;
   logic wr_mask;
   logic wr_prio;
   logic wr_state;
   logic idle;
   logic blocked;
   logic take_brk;
   logic take_nmi;
   logic take_mask;
   logic [N_SRC-1:0] clr_req;
   logic [N_SRC-1:0] wmask;

   // register write decode
   assign wr_req = reg_wr_in && (reg_addr_in == via_pkg::REQ_OFS);
   assign wr_mask = reg_wr_in && (reg_addr_in == via_pkg::MASK_OFS);
   assign wr_prio = reg_wr_in && (reg_addr_in == via_pkg::PRIO_OFS);
   assign wr_state = reg_wr_in && (reg_addr_in == via_pkg::STATE_OFS);
   assign wmask = reg_wdata_in[N_SRC-1:0];
   assign idle = (s_reg.seq == via_pkg::VIA_IDLE);

   // a reserve instruction blocks its own boundary; a flag write blocks the next
   assign blocked = reserve_in | s_reg.defer;

   // decisions only at a boundary while idle, one source per acceptance
   // break is the instruction itself and is never held off
   assign take_brk = boundary_in && idle && brk_in;
   // non-maskable beats everything but break and skips enable and priority
   // none while its own service runs, nests otherwise
   assign take_nmi = boundary_in && idle && !brk_in && !blocked
                     && s_reg.nmi_pend && !s_reg.nmi_act;
   assign take_mask = boundary_in && idle && !brk_in && !blocked
                      && !(s_reg.nmi_pend && !s_reg.nmi_act)
                      && !s_reg.nmi_act && sel.valid;

   // accepted request flag is dropped in the same edge
   always_comb begin
      clr_req = '0;
      if (take_mask) begin
         clr_req[sel.idx] = 1'b1;
      end
   end

   // next-state logic for the whole block
   always_comb begin
      s_next = s_reg;

      // flag registers: software write, then accept clear, then events win
      if (wr_req) begin
         s_next.req = wmask;
      end
      s_next.req = (s_next.req & ~clr_req) | src_event_in;
      if (wr_mask) begin
         s_next.mask = wmask;
      end
      if (wr_prio) begin
         s_next.prio = wmask;
      end

      // deferral for a flag or state write lasts to the next boundary
      if (wr_req || wr_mask || wr_prio || wr_state) begin
         s_next.defer = 1'b1;
      end else if (boundary_in) begin
         s_next.defer = 1'b0;
      end

      // state word changes by software, by enable/disable and by restore
      if (wr_state) begin
         s_next.processor_state_word = reg_wdata_in[7:0];
      end
      if (psw_load_in) begin
         s_next.processor_state_word = psw_load_data_in;
      end
      if (ei_in) begin
         s_next.processor_state_word[via_pkg::IE_BIT] = 1'b1;
      end
      if (di_in) begin
         s_next.processor_state_word[via_pkg::IE_BIT] = 1'b0;
      end

      // vectored return ends non-maskable service; only a break could nest in it
      if (ret_vec_in) begin
         s_next.nmi_act = 1'b0;
      end

      // one latched request however many arrive
      if (take_nmi) begin
         s_next.nmi_pend = 1'b0;
      end
      if (nmi_event_in) begin
         s_next.nmi_pend = 1'b1;
      end

      // acceptance: snapshot state word before flags change
      if (take_brk || take_nmi || take_mask) begin
         s_next.saved = s_reg.processor_state_word;
         s_next.seq = via_pkg::VIA_PUSH_STATE;
         s_next.processor_state_word[via_pkg::IE_BIT] = 1'b0;
      end
      if (take_brk) begin
         s_next.vec = via_pkg::BRK_VECTOR;
         s_next.low = 1'b0;
      end
      if (take_nmi) begin
         s_next.vec = NMI_VECTOR;
         s_next.nmi_act = 1'b1;
         s_next.low = 1'b0;
         s_next.processor_state_word[via_pkg::ISP_BIT] = 1'b0;
      end
      if (take_mask) begin
         s_next.vec = via_pkg::VEC_BASE + {11'h000, sel.idx, 1'b0};
         s_next.low = sel.low;
         s_next.processor_state_word[via_pkg::ISP_BIT] = s_reg.prio[sel.idx];
      end

      // stacking order: state word, pointer, then vector
      unique case (s_reg.seq)
         via_pkg::VIA_IDLE: begin
         end
         via_pkg::VIA_PUSH_STATE: begin
            s_next.seq = via_pkg::VIA_PUSH_PTR;
         end
         via_pkg::VIA_PUSH_PTR: begin
            // low priority costs extra clocks
            if (s_reg.low) begin
               s_next.seq = via_pkg::VIA_WAIT;
               s_next.wait_cnt = via_pkg::LOW_EXTRA - 2'h1;
            end else begin
               s_next.seq = via_pkg::VIA_LOAD;
            end
         end
         via_pkg::VIA_WAIT: begin
            if (s_reg.wait_cnt == 2'h0) begin
               s_next.seq = via_pkg::VIA_LOAD;
            end else begin
               s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
            end
         end
         via_pkg::VIA_LOAD: begin
            s_next.seq = via_pkg::VIA_IDLE;
         end
         default: begin
            s_next.seq = via_pkg::VIA_IDLE;
         end
      endcase

      // read data stands in the cycle after the strobe only
      s_next.rdata = 32'h0000_0000;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            via_pkg::REQ_OFS: s_next.rdata = 32'(s_reg.req);
            via_pkg::MASK_OFS: s_next.rdata = 32'(s_reg.mask);
            via_pkg::PRIO_OFS: s_next.rdata = 32'(s_reg.prio);
            via_pkg::STATE_OFS: s_next.rdata = {24'h000000, s_reg.processor_state_word};
            via_pkg::STATUS_OFS: begin
               s_next.rdata = {28'h0000000, !idle, s_reg.defer, s_reg.nmi_act,
                               s_reg.nmi_pend};
            end
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // single state register, reset to documented values
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_reg.seq <= via_pkg::VIA_IDLE;
         s_reg.processor_state_word <= via_pkg::PSW_RST;
         s_reg.req <= N_SRC'(via_pkg::REQ_RST);
         s_reg.mask <= N_SRC'(via_pkg::MASK_RST);
         s_reg.prio <= N_SRC'(via_pkg::PRIO_RST);
         s_reg.nmi_pend <= 1'b0;
         s_reg.nmi_act <= 1'b0;
         s_reg.defer <= 1'b0;
         s_reg.low <= 1'b0;
         s_reg.wait_cnt <= 2'h0;
         s_reg.saved <= 8'h00;
         s_reg.vec <= 16'h0000;
         s_reg.rdata <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   // core handshake outputs decode the sequencer; data come from flops
   assign busy_out = !idle;
   assign push_state_out = (s_reg.seq == via_pkg::VIA_PUSH_STATE);
   assign push_ptr_out = (s_reg.seq == via_pkg::VIA_PUSH_PTR);
   assign vector_load_out = (s_reg.seq == via_pkg::VIA_LOAD);
   assign state_word_out = s_reg.saved;
   assign vector_out = s_reg.vec;
   assign psw_out = s_reg.processor_state_word;
   assign reg_rdata_out = s_reg.rdata;

   initial begin
      if (N_SRC < 1 || N_SRC > 12) begin
         $error("vectored_interrupt_acknowledge: 1 to 12 maskable sources");
      end
   end
endmodule : vectored_interrupt_acknowledge

// ---- rtl/via_picker.sv ----
// combinational priority picker for the maskable sources
module via_picker #(
   parameter int N_SRC = 12,
   parameter int IDX_W = 4
) (
   via_sel_if.picker sel
);
   // lowest set index wins: source 0 is the fixed highest
   function automatic logic [IDX_W:0] first_set(input logic [N_SRC-1:0] v);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction : first_set

   logic [N_SRC-1:0] elig;
   logic [N_SRC-1:0] elig_hi;
   logic [N_SRC-1:0] elig_lo;
   logic [IDX_W:0] pick_hi;
   logic [IDX_W:0] pick_lo;

   // request set and unmasked; priority flag plays no part here
   assign elig = sel.req & ~sel.mask;
   assign elig_hi = elig & ~sel.prio;
   // low group shut out while high-priority service runs
   assign elig_lo = sel.in_service_priority_flag ? (elig & sel.prio) : '0;
   assign pick_hi = first_set(elig_hi);
   assign pick_lo = first_set(elig_lo);

   // programmable priority first, fixed order inside a group
   always_comb begin
      sel.valid = sel.ie & (pick_hi[IDX_W] | pick_lo[IDX_W]);
      sel.low = ~pick_hi[IDX_W];
      sel.idx = pick_hi[IDX_W] ? pick_hi[IDX_W-1:0] : pick_lo[IDX_W-1:0];
   end

   initial begin
      if (N_SRC < 1 || N_SRC > (1 << IDX_W)) begin
         $error("via_picker: source count does not fit index width");
      end
   end
endmodule : via_picker

// ---- rtl/via_pkg.sv ----
// constants, types and behaviour notes for the vectored interrupt acknowledge block
package via_pkg;
   // register byte offsets on the plain register port
   localparam logic [7:0] REQ_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] PRIO_OFS = 8'h08;
   localparam logic [7:0] STATE_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // state word layout and reset value
   localparam int IE_BIT = 7;
   localparam int ISP_BIT = 1;
   localparam logic [7:0] PSW_RST = 8'h02;
   // flag register reset values: no request, all masked, all low priority
   localparam logic [11:0] REQ_RST = 12'h000;
   localparam logic [11:0] MASK_RST = 12'hFFF;
   localparam logic [11:0] PRIO_RST = 12'hFFF;
   // vectors: maskable table starts at base, two bytes per source
   localparam logic [15:0] VEC_BASE = 16'h0004;
   localparam logic [15:0] BRK_VECTOR = 16'h003E;
   // latency bounds in cpu clocks; low priority costs the difference extra
   localparam int LAT_HI_MIN = 13;
   localparam int LAT_HI_MAX = 63;
   localparam int LAT_LO_MIN = 15;
   localparam int LAT_LO_MAX = 65;
   localparam logic [1:0] LOW_EXTRA = 2'(LAT_LO_MIN - LAT_HI_MIN);
   // acceptance sequencer, gray along idle-push-push-wait-load
   typedef enum logic [2:0] {
      VIA_IDLE = 3'h0,
      VIA_PUSH_STATE = 3'h1,
      VIA_PUSH_PTR = 3'h3,
      VIA_WAIT = 3'h2,
      VIA_LOAD = 3'h6
   } via_seq_e;
endpackage : via_pkg

// ---- rtl/via_sel_if.sv ----
// selector link between the acknowledge logic and the priority picker
interface via_sel_if #(
   parameter int N_SRC = 12,
   parameter int IDX_W = 4
);
   logic [N_SRC-1:0] req;
   logic [N_SRC-1:0] mask;
   logic [N_SRC-1:0] prio;
   logic ie;
   logic in_service_priority_flag;
   logic valid;
   logic low;
   logic [IDX_W-1:0] idx;
   modport picker (input req, mask, prio, ie, in_service_priority_flag, output valid, low, idx);
   modport owner (output req, mask, prio, ie, in_service_priority_flag, input valid, low, idx);
endinterface : via_sel_if

// ---- sim/tb_vectored_interrupt_acknowledge.sv ----
// self-checking bench for the interrupt acknowledge block
module tb_vectored_interrupt_acknowledge;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] NMI_VEC = 16'h0040;
   logic ref_clk_in, rstn_in, reg_wr, reg_rd, busy, pstate, pptr, vload, bnd, rsv_o, brk_o;
   logic step, rsv, brkq, acc, di;
   logic [1:0] gap;
   logic [3:0] ctl;
   logic [7:0] addr, pld, processor_state_word, sword;
   logic [11:0] src;
   logic [15:0] vec, pc;
   logic [31:0] wdata, rdata, rv;
   int miscompares, checked, lat;
   logic [7:0] offs [6] = '{via_pkg::REQ_OFS, via_pkg::MASK_OFS, via_pkg::PRIO_OFS,
      via_pkg::STATE_OFS, via_pkg::STATUS_OFS, 8'hFC};
   logic [31:0] exp_rd [6] = '{32'h0, 32'hFFF, 32'hFFF, 32'h2, 32'h0, 32'h0};

   vectored_interrupt_acknowledge #(.N_SRC(12), .NMI_VECTOR(NMI_VEC)) dut (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .src_event_in(src),
      .nmi_event_in(ctl[3]), .boundary_in(bnd), .reserve_in(rsv_o), .brk_in(brk_o),
      .ret_vec_in(ctl[1]), .ei_in(ctl[0]), .di_in(di), .psw_load_in(ctl[2]),
      .psw_load_data_in(pld), .psw_out(processor_state_word), .busy_out(busy), .push_state_out(pstate),
      .state_word_out(sword), .push_ptr_out(pptr), .vector_load_out(vload), .vector_out(vec));
   via_core_model core (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .step_in(step),
      .rsv_in(rsv), .brk_req_in(brkq), .gap_in(gap), .busy_in(busy), .vector_load_in(vload),
      .vector_in(vec), .boundary_out(bnd), .reserve_out(rsv_o), .brk_out(brk_o), .pc_out(pc));

   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic reset_dut();
      rstn_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
   endtask : reset_dut

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk_in);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd <= 1'b0;
      #1;
      rv = rdata;
   endtask : rd_reg

   // one-cycle core events: bit0 enable, bit1 vectored return, bit2 state load, bit3 nmi
   task automatic pulse(input logic [3:0] c, input logic [11:0] s, input logic [7:0] d);
      @(posedge ref_clk_in);
      ctl <= c;
      src <= s;
      pld <= d;
      @(posedge ref_clk_in);
      ctl <= 4'h0;
      src <= 12'h000;
      #1;
   endtask : pulse

   // one instruction completes; lat counts cycles from state push to vector load
   task automatic instr(input logic r, input logic b);
      @(posedge ref_clk_in);
      step <= 1'b1;
      rsv <= r;
      brkq <= b;
      @(posedge ref_clk_in);
      step <= 1'b0;
      for (int n = 0; n < 20 && bnd !== 1'b1; n++) begin
         @(posedge ref_clk_in);
         #1;
      end
      @(posedge ref_clk_in);
      #1;
      acc = busy;
      for (lat = 1; acc === 1'b1 && lat < 20 && vload !== 1'b1; lat++) begin
         @(posedge ref_clk_in);
         #1;
      end
      @(posedge ref_clk_in);
      #1;
   endtask : instr

   task automatic no_acc(input string what, input logic r);
      instr(r, 1'b0);
      chk(what, 32'(acc), 32'h0);
   endtask : no_acc

   task automatic expect_acc(input string what, input logic b, input logic [15:0] v,
      input logic [7:0] p, input int l);
      instr(1'b0, b);
      chk(what, 32'(acc), 32'h1);
      chk(what, 32'(vec), 32'(v));
      chk(what, 32'(processor_state_word), 32'(p));
      chk(what, 32'(lat), 32'(l));
      chk(what, 32'(pc), 32'(v));
   endtask : expect_acc

   initial begin
      repeat (4000) @(posedge ref_clk_in);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      {step, rsv, brkq, reg_wr, reg_rd, di} = 6'h00;
      gap = 2'h0;
      ctl = 4'h0;
      src = 12'h000;
      addr = 8'h00;
      pld = 8'h00;
      wdata = 32'h0;
      reset_dut();
      chk("psw", 32'(processor_state_word), 32'(via_pkg::PSW_RST));
      foreach (offs[i]) begin
         rd_reg(offs[i]);
         chk("reg", rv, exp_rd[i]);
      end
      $display("test reset finished");
      // sources 2 low, 7 and 9 high, all raised together
      wr_reg(via_pkg::MASK_OFS, 32'hD7B);
      wr_reg(via_pkg::PRIO_OFS, 32'hD7F);
      pulse(4'h1, 12'h284, 8'h00);
      rd_reg(via_pkg::REQ_OFS);
      chk("req", rv, 32'h284);
      no_acc("ei", 1'b1);
      expect_acc("src7", 1'b0, 16'h0012, 8'h00, 3);
      chk("saved", 32'(sword), 32'h82);
      pulse(4'h1, 12'h000, 8'h00);
      no_acc("ei", 1'b1);
      expect_acc("src9", 1'b0, 16'h0016, 8'h00, 3);
      pulse(4'h1, 12'h000, 8'h00);
      no_acc("ei", 1'b1);
      no_acc("low", 1'b0);
      pulse(4'h6, 12'h000, 8'h82);
      chk("pop", 32'(processor_state_word), 32'h82);
      // disable pulse drops accept-enable only
      @(posedge ref_clk_in);
      di <= 1'b1;
      @(posedge ref_clk_in);
      di <= 1'b0;
      #1;
      chk("di", 32'(processor_state_word), 32'h02);
      pulse(4'h1, 12'h000, 8'h00);
      no_acc("ret", 1'b1);
      expect_acc("src2", 1'b0, 16'h0008, 8'h02, 5);
      $display("test nesting finished");
      reset_dut();
      pulse(4'h8, 12'h000, 8'h00);
      expect_acc("nmi", 1'b0, NMI_VEC, 8'h00, 3);
      pulse(4'h8, 12'h000, 8'h00);
      pulse(4'h8, 12'h000, 8'h00);
      no_acc("nest", 1'b0);
      pulse(4'h6, 12'h000, 8'h02);
      no_acc("ret", 1'b1);
      expect_acc("nmi2", 1'b0, NMI_VEC, 8'h00, 3);
      pulse(4'h6, 12'h000, 8'h02);
      no_acc("ret", 1'b1);
      no_acc("once", 1'b0);
      $display("test nmi finished");
      // slow core; break follows a deferring write yet is taken
      gap = 2'h2;
      pulse(4'h1, 12'h000, 8'h00);
      wr_reg(via_pkg::MASK_OFS, 32'h0);
      expect_acc("brk", 1'b1, via_pkg::BRK_VECTOR, 8'h02, 3);
      chk("saved", 32'(sword), 32'h82);
      pulse(4'h8, 12'h001, 8'h00);
      expect_acc("nmi in brk", 1'b0, NMI_VEC, 8'h00, 3);
      rd_reg(via_pkg::REQ_OFS);
      chk("held", rv, 32'h1);
      pulse(4'h6, 12'h000, 8'h02);
      pulse(4'h1, 12'h000, 8'h00);
      no_acc("ei", 1'b1);
      expect_acc("src0", 1'b0, 16'h0004, 8'h02, 5);
      pulse(4'h6, 12'h000, 8'h02);
      pulse(4'h4, 12'h000, 8'h02);
      chk("brk ret", 32'(processor_state_word), 32'h02);
      $display("test break finished");
      tally_and_finish();
   end
endmodule : tb_vectored_interrupt_acknowledge

// ---- sim/via_core_model.sv ----
// core stand-in: gives instruction boundaries and follows vectors
module via_core_model (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic step_in,
   input wire logic rsv_in,
   input wire logic brk_req_in,
   input wire logic [1:0] gap_in,
   input wire logic busy_in,
   input wire logic vector_load_in,
   input wire logic [15:0] vector_in,
   output logic boundary_out,
   output logic reserve_out,
   output logic brk_out,
   output logic [15:0] pc_out
);
   logic pend_reg, rsv_reg, brk_reg, fire;
   logic [1:0] wait_reg;
   // a slow core idles gap_in cycles; never a boundary while busy
   assign fire = pend_reg && !busy_in && !boundary_out && wait_reg >= gap_in;
   // qualifiers toggle off boundary so nothing leans on stale values
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend_reg <= 1'b0;
         rsv_reg <= 1'b0;
         brk_reg <= 1'b0;
         wait_reg <= 2'h0;
         boundary_out <= 1'b0;
         reserve_out <= 1'b0;
         brk_out <= 1'b0;
         pc_out <= 16'h0000;
      end else begin
         if (step_in) begin
            pend_reg <= 1'b1;
            rsv_reg <= rsv_in;
            brk_reg <= brk_req_in;
         end else if (fire) begin
            pend_reg <= 1'b0;
         end
         wait_reg <= (pend_reg && !fire) ? wait_reg + 2'(wait_reg != 2'h3) : 2'h0;
         boundary_out <= fire;
         reserve_out <= fire ? rsv_reg : ~reserve_out;
         brk_out <= fire ? brk_reg : ~brk_out;
         if (vector_load_in) begin
            pc_out <= vector_in;
         end
      end
   end
endmodule : via_core_model

// ---- sim/via_monitor.sv ----
// port checker for the interrupt acknowledge block
module via_monitor (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic boundary_in,
   input wire logic brk_in,
   input wire logic [7:0] psw_out,
   input wire logic busy_out,
   input wire logic push_state_out,
   input wire logic [7:0] state_word_out,
   input wire logic push_ptr_out,
   input wire logic vector_load_out,
   input wire logic [15:0] vector_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // acceptance starts only from a boundary
   accept_start_a: assert property (
      $rose(busy_out) |-> push_state_out && $past(boundary_in))
      else $error("acceptance without boundary");
   // state goes first, pointer next
   push_order_a: assert property (
      push_state_out |=> push_ptr_out && !push_state_out)
      else $error("pointer push out of order");
   load_time_a: assert property (
      push_ptr_out |-> ##[1:3] vector_load_out)
      else $error("vector load late");
   ie_clear_a: assert property (
      push_state_out |-> !psw_out[via_pkg::IE_BIT])
      else $error("enable not cleared");
   saved_state_a: assert property (
      $rose(busy_out) |-> state_word_out == $past(psw_out))
      else $error("saved state word wrong");
   // with enable low only the non-maskable or break may start
   nmi_only_a: assert property (
      $rose(busy_out) && !$past(psw_out[via_pkg::IE_BIT]) && !$past(brk_in)
      |-> !psw_out[via_pkg::ISP_BIT])
      else $error("maskable taken while disabled");
   one_load_a: assert property (
      vector_load_out |=> !busy_out && !vector_load_out)
      else $error("busy after vector load");
   vec_hold_a: assert property (
      busy_out && !push_state_out |-> $stable(vector_out))
      else $error("vector moved during sequence");
   brk_vec_a: assert property (
      $rose(busy_out) && $past(brk_in) |-> vector_out == via_pkg::BRK_VECTOR
      && psw_out[via_pkg::ISP_BIT] == $past(psw_out[via_pkg::ISP_BIT]))
      else $error("break vector or priority wrong");
endmodule : via_monitor

bind vectored_interrupt_acknowledge via_monitor mon (.ref_clk_in(ref_clk_in),
   .rstn_in(rstn_in), .boundary_in(boundary_in), .brk_in(brk_in), .psw_out(psw_out),
   .busy_out(busy_out), .push_state_out(push_state_out), .state_word_out(state_word_out),
   .push_ptr_out(push_ptr_out), .vector_load_out(vector_load_out), .vector_out(vector_out));
